/* File: hdl/asr_consts.svh */
// constants for the asynchronous serial receiver
// assumes one 50 MHz clock and that the action list is loaded before start
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH
`define ASR_CLK_MHZ 50
`define ASR_PERIOD_OFS_US 20
`define ASR_MS_CYC (1000 * `ASR_CLK_MHZ)
`define ASR_HOST_PIN 5'h10
`define ASR_BITS_8N 4'h8
`define ASR_BITS_7E 4'h7
`define ASR_SEQ_MAX 6
`define ASR_CH_0 8'h30
`define ASR_CH_1 8'h31
`define ASR_CH_9 8'h39
`define ASR_CH_UA 8'h41
`define ASR_CH_UF 8'h46
`define ASR_CH_PLUS 8'h2b
`define ASR_CH_MINUS 8'h2d
`define ASR_HEX_OFS 8'h37
`endif

/* File: hdl/asr_pkg.sv */
// types shared by the serial receiver files
// assumes nothing beyond a SystemVerilog compiler
package asr_pkg;
    // 16-bit format word, msb first
    typedef struct packed {
        logic unused;
        logic inv;
        logic seven;
        logic [12:0] period;
    } asr_fmt_t;
    typedef enum logic [2:0] {
        K_STORE = 3'h0, K_DEC = 3'h1, K_BIN = 3'h2,
        K_HEX = 3'h3, K_WAIT = 3'h4, K_SKIP = 3'h5
    } asr_kind_t;
    // one entry of the receive action list
    typedef struct packed {
        asr_kind_t kind;
        logic sgn;
        logic [3:0] cnt;
        logic [47:0] seq;
    } asr_act_t;
    typedef struct packed {
        logic [4:0] rpin;
        logic fpin_en;
        logic [3:0] fpin;
        asr_fmt_t fmt;
        logic perr_en;
        logic tmo_en;
        logic [15:0] tmo_ms;
        logic [3:0] act_count;
    } asr_cfg_t;
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [7:0] data;
    } asr_byte_t;
    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [15:0] value;
    } asr_num_t;
    typedef struct packed {
        logic done;
        logic perr;
        logic tmo;
    } asr_exit_t;
    typedef enum logic [2:0] {
        R_IDLE = 3'h0, R_HUNT = 3'h1, R_START = 3'h3,
        R_DATA = 3'h2, R_PAR = 3'h6, R_STOP = 3'h7
    } asr_rx_st_t;
    typedef enum logic [1:0] {
        E_IDLE = 2'h0, E_FETCH = 2'h1, E_LOAD = 2'h3, E_RUN = 2'h2
    } asr_eng_st_t;
endpackage

/* File: hdl/asr_act_mem.sv */
// action list memory, eight entries, registered read
// assumes writes happen only while the receiver is idle
`timescale 1ns/10ps
`default_nettype none
module asr_act_mem
    import asr_pkg::*;
(
    // clocking
    input wire logic clk,
    input wire logic ce,
    // write port
    input wire logic we,
    input wire logic [2:0] waddr,
    input wire asr_act_t wdata,
    // read port
    input wire logic [2:0] raddr,
    output asr_act_t rdata
);
    asr_act_t mem [0:7];

    // no reset: contents are loaded by the user
    always_ff @(posedge clk) begin
        if (ce) begin
            if (we) begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end
endmodule
`default_nettype wire

/* File: hdl/asr_rx.sv */
// asynchronous serial receiver with an action list
// assumes pins_i and host_serial_input are asynchronous, all else on clk
`include "asr_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module asr_rx
    import asr_pkg::*;
#(
    parameter int unsigned MS_CYC = `ASR_MS_CYC
)(
    // clocking
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // control
    input wire logic start_i,
    input wire asr_cfg_t cfg_i,
    // action list load
    input wire logic act_we,
    input wire logic [2:0] act_waddr,
    input wire asr_act_t act_wdata,
    // pins
    input wire logic host_serial_input,
    input wire logic [15:0] pins_i,
    output logic [15:0] pin_o,
    output logic [15:0] pin_oe_n,
    // results
    output logic busy_o,
    output asr_byte_t byte_o,
    output asr_num_t num_o,
    output asr_exit_t exit_o
);
    asr_cfg_t cfg_r;
    asr_act_t act_rd, act_r;
    asr_rx_st_t rx_r, rx_nxt;
    asr_eng_st_t eng_r, eng_nxt;
    logic busy_r, busy_nxt;
    logic s1_r, s2_r, s3_r, line_r;
    logic [18:0] tmr_r, tmr_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic par_r, par_nxt;
    logic stb, perr;
    logic [2:0] idx_r, idx_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic [3:0] ndig_r, ndig_nxt;
    logic nst_r, nst_nxt, neg_r, neg_nxt;
    logic [47:0] hist_r, hist_nxt;
    logic [15:0] pre_r, ms_r;
    asr_byte_t byte_nxt;
    asr_num_t num_nxt;
    asr_exit_t exit_nxt;
    logic [15:0] oe_n_nxt, pin_nxt;

    // digit decode: {ok, value}
    function automatic logic [4:0] digit(input asr_kind_t k, input logic [7:0] b);
        logic [7:0] v;
        v = 8'h00;
        digit = 5'h00;
        case (k)
            K_BIN: if (b == `ASR_CH_0 || b == `ASR_CH_1) digit = {1'b1, 4'(b - `ASR_CH_0)};
            K_DEC: if (b >= `ASR_CH_0 && b <= `ASR_CH_9) digit = {1'b1, 4'(b - `ASR_CH_0)};
            K_HEX: begin
                if (b >= `ASR_CH_0 && b <= `ASR_CH_9) v = b - `ASR_CH_0;
                else if (b >= `ASR_CH_UA && b <= `ASR_CH_UF) v = b - `ASR_HEX_OFS;
                else v = 8'hff;
                if (v != 8'hff) digit = {1'b1, v[3:0]};
            end
            default: digit = 5'h00;
        endcase
    endfunction

    // one accumulate step, truncated to 16 bits
    function automatic logic [15:0] step(input asr_kind_t k, input logic [15:0] a, input logic [3:0] d);
        case (k)
            K_BIN: step = 16'({a, 1'b0} + 17'(d));
            K_HEX: step = 16'({a, 4'h0} + 20'(d));
            default: step = 16'({a, 3'h0} + {a, 1'b0} + 19'(d));
        endcase
    endfunction

    // byte mask for a match of n bytes, newest in the low byte
    function automatic logic [47:0] seq_mask(input logic [3:0] n);
        seq_mask = 48'h0;
        for (int i = 0; i < `ASR_SEQ_MAX; i++) begin
            if (i < int'(n)) seq_mask[i*8 +: 8] = 8'hff;
        end
    endfunction

    // bit period in cycles from the format word
    // same encoding the sender tables use
    function automatic logic [18:0] per_cyc(input asr_fmt_t f);
        per_cyc = 19'((32'(f.period) + `ASR_PERIOD_OFS_US) * `ASR_CLK_MHZ);
    endfunction

    // bit 15 of the format is never read
    wire logic inv = cfg_r.fmt.inv;
    wire logic seven = cfg_r.fmt.seven;
    // 20us period floor, 50 kbps top
    wire logic [18:0] per = per_cyc(cfg_r.fmt);
    wire logic [18:0] half = {1'b0, per[18:1]};
    wire logic [3:0] nbits = seven ? `ASR_BITS_7E : `ASR_BITS_8N;
    // 16 selects the host input, else a general pin
    wire logic raw_pin = (cfg_r.rpin == `ASR_HOST_PIN) ? host_serial_input : pins_i[cfg_r.rpin[3:0]];
    // normalise so idle is one and start is zero
    wire logic bit_n = line_r ^ inv;
    wire logic tick = (tmr_r == 19'h0);
    // 7E bytes keep seven bits only
    wire logic [7:0] rx_byte = seven ? {1'b0, sh_r[7:1]} : sh_r;
    wire logic [4:0] dg = digit(act_r.kind, rx_byte);
    wire logic is_sign = act_r.sgn && (rx_byte == `ASR_CH_PLUS || rx_byte == `ASR_CH_MINUS);
    wire logic [47:0] hist_sh = {hist_r[39:0], rx_byte};
    wire logic [47:0] msk = seq_mask(act_r.cnt);
    wire logic seq_hit = ((hist_sh ^ act_r.seq) & msk) == 48'h0;
    wire logic last_act = ({1'b0, idx_r} + 4'h1) >= cfg_r.act_count;
    wire logic start_ok = start_i && !busy_r;
    // timer fires when the wait reaches the limit
    // only honoured when the timeout pair is present
    wire logic tmo_hit = busy_r && cfg_r.tmo_en && (ms_r == cfg_r.tmo_ms);
    wire logic [15:0] acc_out = neg_r ? 16'(-acc_r) : acc_r;
    // ready level follows polarity, asserted while hunting
    wire logic rdy_lvl = (busy_nxt && rx_nxt == R_HUNT) ? inv : ~inv;

    // three-stage synchroniser, line changes once stages two and three agree
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            line_r <= 1'b1;
        end else if (ce) begin
            s1_r <= raw_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) line_r <= s3_r;
        end
    end

    // bit-level receive state machine
    always_comb begin
        rx_nxt = rx_r;
        tmr_nxt = tick ? tmr_r : tmr_r - 19'h1;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        par_nxt = par_r;
        stb = 1'b0;
        perr = 1'b0;
        case (rx_r)
            R_HUNT: if (!bit_n) begin
                rx_nxt = R_START;
                tmr_nxt = half;
            end
            R_START: if (tick) begin
                rx_nxt = bit_n ? R_HUNT : R_DATA;
                tmr_nxt = per - 19'h1;
                bit_nxt = 4'h0;
            end
            R_DATA: if (tick) begin
                sh_nxt = {bit_n, sh_r[7:1]};
                bit_nxt = bit_r + 4'h1;
                tmr_nxt = per - 19'h1;
                // seven bits plus parity or eight bits
                if (bit_r == nbits - 4'h1) rx_nxt = seven ? R_PAR : R_STOP;
            end
            R_PAR: if (tick) begin
                par_nxt = bit_n;
                rx_nxt = R_STOP;
                tmr_nxt = per - 19'h1;
            end
            // one stop bit, a missing stop drops the byte
            R_STOP: if (tick) begin
                rx_nxt = R_HUNT;
                stb = bit_n;
                // recompute even parity over data and parity bit
                perr = seven && ((^sh_r[7:1]) ^ par_r);
            end
            default: rx_nxt = R_IDLE;
        endcase
    end

    // action engine and exits
    always_comb begin
        eng_nxt = eng_r;
        busy_nxt = busy_r;
        idx_nxt = idx_r;
        cnt_nxt = cnt_r;
        acc_nxt = acc_r;
        ndig_nxt = ndig_r;
        nst_nxt = nst_r;
        neg_nxt = neg_r;
        hist_nxt = hist_r;
        byte_nxt = '0;
        num_nxt = '0;
        exit_nxt = '0;
        oe_n_nxt = pin_oe_n;
        if (start_ok) begin
            busy_nxt = 1'b1;
            idx_nxt = 3'h0;
            eng_nxt = E_FETCH;
            if (!cfg_i.rpin[4]) oe_n_nxt[cfg_i.rpin[3:0]] = 1'b1;
            if (cfg_i.fpin_en) oe_n_nxt[cfg_i.fpin] = 1'b0;
        end else if (busy_r) begin
            case (eng_r)
                E_FETCH: eng_nxt = E_LOAD;
                E_LOAD: begin
                    eng_nxt = E_RUN;
                    cnt_nxt = {act_rd.cnt == 4'h0, act_rd.cnt};
                    acc_nxt = 16'h0;
                    ndig_nxt = 4'h0;
                    nst_nxt = 1'b0;
                    neg_nxt = 1'b0;
                    hist_nxt = 48'h0;
                end
                E_RUN: if (stb) begin
                    // each action kind consumes the byte its own way
                    case (act_r.kind)
                        K_STORE: begin
                            byte_nxt = '{valid: 1'b1, idx: idx_r, data: rx_byte};
                            cnt_nxt = cnt_r - 5'h1;
                        end
                        K_SKIP: cnt_nxt = cnt_r - 5'h1;
                        // exact match of the last n bytes
                        K_WAIT: begin
                            hist_nxt = hist_sh;
                            if (seq_hit) cnt_nxt = 5'h0;
                        end
                        // skip junk, accumulate, stop on non-digit or count
                        default: begin
                            if (dg[4]) begin
                                acc_nxt = step(act_r.kind, nst_r ? acc_r : 16'h0, dg[3:0]);
                                ndig_nxt = ndig_r + 4'h1;
                                nst_nxt = 1'b1;
                                if (act_r.cnt != 4'h0 && ndig_r + 4'h1 == act_r.cnt) cnt_nxt = 5'h0;
                            end else if (!nst_r && is_sign) begin
                                nst_nxt = 1'b1;
                                neg_nxt = (rx_byte == `ASR_CH_MINUS);
                            end else if (nst_r) begin
                                cnt_nxt = 5'h0;
                            end
                        end
                    endcase
                end
                default: eng_nxt = E_IDLE;
            endcase
            // action finished: move on or end
            if (eng_r == E_RUN && stb && cnt_nxt == 5'h0) begin
                if (act_r.kind inside {K_DEC, K_BIN, K_HEX}) begin
                    num_nxt.valid = 1'b1;
                    num_nxt.idx = idx_r;
                    num_nxt.value = neg_nxt ? 16'(-acc_nxt) : acc_nxt;
                end
                if (last_act) begin
                    busy_nxt = 1'b0;
                    eng_nxt = E_IDLE;
                    exit_nxt.done = 1'b1;
                end else begin
                    idx_nxt = idx_r + 3'h1;
                    eng_nxt = E_FETCH;
                end
            end
            // parity exit only with the target in 7E mode
            if (stb && perr && cfg_r.perr_en && seven) begin
                busy_nxt = 1'b0;
                eng_nxt = E_IDLE;
                exit_nxt = '{done: 1'b0, perr: 1'b1, tmo: 1'b0};
                byte_nxt = '0;
                num_nxt = '0;
            end else if (tmo_hit && !stb) begin
                busy_nxt = 1'b0;
                eng_nxt = E_IDLE;
                exit_nxt = '{done: 1'b0, perr: 1'b0, tmo: 1'b1};
            end
        end
    end

    always_comb begin
        pin_nxt = 16'h0;
        if (cfg_r.fpin_en) pin_nxt[cfg_r.fpin] = rdy_lvl;
    end

    // configuration capture at start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) cfg_r <= '0;
        else if (ce && start_ok) cfg_r <= cfg_i;
    end

    // receive state registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_r <= R_IDLE;
            tmr_r <= 19'h0;
            bit_r <= 4'h0;
            sh_r <= 8'h0;
            par_r <= 1'b0;
        end else if (ce) begin
            rx_r <= busy_nxt ? ((rx_r == R_IDLE) ? R_HUNT : rx_nxt) : R_IDLE;
            tmr_r <= tmr_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            par_r <= par_nxt;
        end
    end

    // engine registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            eng_r <= E_IDLE;
            busy_r <= 1'b0;
            idx_r <= 3'h0;
            act_r <= '0;
            cnt_r <= 5'h0;
            acc_r <= 16'h0;
            ndig_r <= 4'h0;
            nst_r <= 1'b0;
            neg_r <= 1'b0;
            hist_r <= 48'h0;
        end else if (ce) begin
            eng_r <= eng_nxt;
            busy_r <= busy_nxt;
            idx_r <= idx_nxt;
            if (eng_r == E_LOAD) act_r <= act_rd;
            cnt_r <= cnt_nxt;
            acc_r <= acc_nxt;
            ndig_r <= ndig_nxt;
            nst_r <= nst_nxt;
            neg_r <= neg_nxt;
            hist_r <= hist_nxt;
        end
    end

    // millisecond wait counter, restarted by each byte
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pre_r <= 16'h0;
            ms_r <= 16'h0;
        end else if (ce) begin
            if (!busy_r || stb) begin
                pre_r <= 16'h0;
                ms_r <= 16'h0;
            end else if (pre_r == 16'(MS_CYC - 1)) begin
                pre_r <= 16'h0;
                if (!tmo_hit) ms_r <= ms_r + 16'h1;
            end else begin
                pre_r <= pre_r + 16'h1;
            end
        end
    end

    // output registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pin_o <= 16'h0;
            pin_oe_n <= 16'hffff;
            busy_o <= 1'b0;
            byte_o <= '0;
            num_o <= '0;
            exit_o <= '0;
        end else if (ce) begin
            pin_o <= pin_nxt;
            pin_oe_n <= oe_n_nxt;
            busy_o <= busy_nxt;
            byte_o <= byte_nxt;
            num_o <= num_nxt;
            exit_o <= exit_nxt;
        end
    end

    asr_act_mem u_mem (
        .clk(clk),
        .ce(ce),
        .we(act_we),
        .waddr(act_waddr),
        .wdata(act_wdata),
        .raddr(idx_r),
        .rdata(act_rd)
    );
endmodule
`default_nettype wire

/* File: verification/asr_rx_monitor.sv */
// assertion checker for the serial receiver top ports
// assumes one clock domain and an async active-low reset
`timescale 1ns/10ps
`default_nettype none
module asr_rx_monitor
    import asr_pkg::*;
#(
    parameter int unsigned MS_CYC = 50000
)(
    // clocking
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    // control
    input wire logic start_i,
    input wire asr_cfg_t cfg_i,
    // action list load
    input wire logic act_we,
    input wire logic [2:0] act_waddr,
    input wire asr_act_t act_wdata,
    // pins
    input wire logic host_serial_input,
    input wire logic [15:0] pins_i,
    input wire logic [15:0] pin_o,
    input wire logic [15:0] pin_oe_n,
    // results
    input wire logic busy_o,
    input wire asr_byte_t byte_o,
    input wire asr_num_t num_o,
    input wire asr_exit_t exit_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    asr_cfg_t cfg_r;
    logic take;
    // a start is taken when idle and enabled
    assign take = start_i && !busy_o && ce;
    // configuration held since the last start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_r <= '0;
        end else if (take) begin
            cfg_r <= cfg_i;
        end
    end
    sequence s_take;
        take;
    endsequence
    sequence s_exit;
        exit_o.done || exit_o.perr || exit_o.tmo;
    endsequence
    property p_busy; s_take |=> busy_o; endproperty
    property p_oe_in; s_take ##0 (cfg_i.rpin < 5'h10) |=> pin_oe_n[$past(cfg_i.rpin[3:0])]; endproperty
    property p_oe_out; s_take ##0 cfg_i.fpin_en |=> !pin_oe_n[$past(cfg_i.fpin)]; endproperty
    property p_oe_keep; !take |=> ((pin_oe_n & ~$past(pin_oe_n)) == 16'h0); endproperty
    property p_perr; exit_o.perr |-> cfg_r.fmt.seven && cfg_r.perr_en; endproperty
    property p_tmo; exit_o.tmo |-> cfg_r.tmo_en; endproperty
    property p_b7; byte_o.valid && cfg_r.fmt.seven |-> !byte_o.data[7]; endproperty
    property p_excl; s_exit |-> $onehot0({exit_o.done, exit_o.perr, exit_o.tmo}) && !busy_o; endproperty
    property p_quiet; exit_o.perr |-> !byte_o.valid && !num_o.valid; endproperty
    property p_pulse; byte_o.valid || num_o.valid |=> !byte_o.valid && !num_o.valid; endproperty
    a_busy: assert property (p_busy) else $error("busy did not rise after start");
    a_oe_in: assert property (p_oe_in) else $error("receive pin not an input");
    a_oe_out: assert property (p_oe_out) else $error("flow pin not an output");
    a_oe_keep: assert property (p_oe_keep) else $error("pin direction changed without start");
    a_perr: assert property (p_perr) else $error("parity exit not allowed");
    a_tmo: assert property (p_tmo) else $error("timeout exit without timeout");
    a_b7: assert property (p_b7) else $error("seven bit byte above 127");
    a_excl: assert property (p_excl) else $error("exit pulses overlap or busy stays");
    a_quiet: assert property (p_quiet) else $error("result beside parity exit");
    a_pulse: assert property (p_pulse) else $error("result pulse too long");
endmodule
bind asr_rx asr_rx_monitor #(.MS_CYC(MS_CYC)) asr_rx_monitor_inst (.clk(clk), .nrst(nrst), .ce(ce),
    .start_i(start_i), .cfg_i(cfg_i), .act_we(act_we), .act_waddr(act_waddr), .act_wdata(act_wdata),
    .host_serial_input(host_serial_input), .pins_i(pins_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n),
    .busy_o(busy_o), .byte_o(byte_o), .num_o(num_o), .exit_o(exit_o));
`default_nettype wire

/* File: verification/asr_tx_model.sv */
// serial transmitter on the far side of the receive pin
// assumes send is called at a falling clock edge
`timescale 1ns/10ps
`default_nettype none
module asr_tx_model (
    // clocking
    input wire logic clk,
    // serial line
    output logic line
);
    logic inv = 1'b0;
    // idle line sits at mark level
    initial line = 1'b1;
    task automatic set_inv(input logic i);
        inv = i;
        line = ~i;
    endtask
    task automatic send(input logic [7:0] d, input logic seven, input logic bad, input int per);
        logic [9:0] fr;
        fr = seven ? {1'b1, (^d[6:0]) ^ bad, d[6:0], 1'b0} : {1'b1, d, 1'b0};
        for (int k = 0; k < 10; k++) begin
            line = fr[k] ^ inv;
            repeat (per) @(negedge clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the serial receiver
// assumes a zero period field, giving 1000 cycles a bit
`timescale 1ns/10ps
`default_nettype none
module tb;
    import asr_pkg::*;
    localparam int PER = 1000;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic start_i = 1'b0;
    asr_cfg_t cfg_i = '0;
    logic act_we = 1'b0;
    logic [2:0] act_waddr = 3'h0;
    asr_act_t act_wdata = '0;
    logic line;
    logic [4:0] sel = 5'h10;
    logic host_serial_input;
    logic [15:0] pins_i;
    logic [15:0] pin_o;
    logic [15:0] pin_oe_n;
    logic busy_o;
    asr_byte_t byte_o;
    asr_num_t num_o;
    asr_exit_t exit_o;
    asr_exit_t got_exit = '0;
    logic [7:0] got_byte = 8'h0;
    logic [15:0] got_num = 16'h0;
    int n_mismatch = 0;
    int checked = 0;
    int cyc = 0;
    always #10 clk = ~clk;
    // route the transmitter line to the selected pin
    assign host_serial_input = (sel == 5'h10) ? line : 1'b1;
    assign pins_i = (sel == 5'h10) ? 16'hffff : (16'hffff & ~(16'h1 << sel[3:0])) | ({15'h0, line} << sel[3:0]);
    asr_rx #(.MS_CYC(50)) asr_rx_inst (.clk(clk), .nrst(nrst), .ce(1'b1), .start_i(start_i), .cfg_i(cfg_i),
        .act_we(act_we), .act_waddr(act_waddr), .act_wdata(act_wdata), .host_serial_input(host_serial_input),
        .pins_i(pins_i), .pin_o(pin_o), .pin_oe_n(pin_oe_n), .busy_o(busy_o), .byte_o(byte_o),
        .num_o(num_o), .exit_o(exit_o));
    asr_tx_model tx (.clk(clk), .line(line));
    // catch result pulses
    always @(posedge clk) begin
        if (byte_o.valid === 1'b1) got_byte = byte_o.data;
        if (num_o.valid === 1'b1) got_num = num_o.value;
        if (|exit_o) got_exit = exit_o;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic cmp_flag(input string what, input logic exp, input logic got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic load(input logic [2:0] a, input asr_act_t d);
        @(negedge clk);
        act_we = 1'b1;
        act_waddr = a;
        act_wdata = d;
        @(negedge clk);
        act_we = 1'b0;
    endtask
    task automatic run(input asr_cfg_t c);
        @(negedge clk);
        got_exit = '0;
        got_byte = 8'h0;
        got_num = 16'h0;
        cfg_i = c;
        start_i = 1'b1;
        @(negedge clk);
        start_i = 1'b0;
    endtask
    task automatic wait_exit();
        for (int i = 0; i < 3000 && got_exit === 3'h0; i++) @(negedge clk);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        // stored byte on host input at top rate, flow pin 2, spare bit set
        load(3'h0, '{kind: K_STORE, sgn: 1'b0, cnt: 4'h1, seq: 48'h0});
        run('{rpin: 5'h10, fpin_en: 1'b1, fpin: 4'h2, fmt: 16'h8000, perr_en: 1'b0, tmo_en: 1'b0,
            tmo_ms: 16'h0, act_count: 4'h1});
        cmp_flag("flow dir", 1'b0, pin_oe_n[2]);
        repeat (10) @(negedge clk);
        cmp_flag("flow ready", 1'b0, pin_o[2]);
        tx.send(8'ha5, 1'b0, 1'b0, PER);
        wait_exit();
        cmp("byte", 16'h00a5, {8'h0, got_byte});
        cmp_flag("done", 1'b1, got_exit.done);
        cmp_flag("flow end", 1'b1, pin_o[2]);
        $display("test 1 done");
        // seven bit inverted on pin 2, the former flow pin, good then bad parity
        sel = 5'h2;
        tx.set_inv(1'b1);
        repeat (10) @(negedge clk);
        for (int b = 0; b < 2; b++) begin
            run('{rpin: 5'h2, fpin_en: 1'b0, fpin: 4'h0, fmt: 16'h6000, perr_en: 1'b1, tmo_en: 1'b0,
                tmo_ms: 16'h0, act_count: 4'h1});
            cmp_flag("rx dir", 1'b1, pin_oe_n[2]);
            repeat (10) @(negedge clk);
            tx.send(8'hc5, 1'b1, b[0], PER);
            wait_exit();
            cmp("byte 7e", b ? 16'h0 : 16'h0045, {8'h0, got_byte});
            cmp_flag("perr", b[0], got_exit.perr);
        end
        $display("test 2 done");
        // no data, timeout of 2 counts, 100 cycles with MS_CYC at 50
        run('{rpin: 5'h2, fpin_en: 1'b0, fpin: 4'h0, fmt: 16'h4000, perr_en: 1'b0, tmo_en: 1'b1,
            tmo_ms: 16'h2, act_count: 4'h1});
        wait_exit();
        cmp_flag("tmo", 1'b1, got_exit.tmo);
        cmp_flag("no done", 1'b0, got_exit.done);
        $display("test 3 done");
        // wait for 'A' then two binary digits on pin 5
        sel = 5'h5;
        tx.set_inv(1'b0);
        load(3'h0, '{kind: K_WAIT, sgn: 1'b0, cnt: 4'h1, seq: 48'h41});
        load(3'h1, '{kind: K_BIN, sgn: 1'b0, cnt: 4'h2, seq: 48'h0});
        repeat (10) @(negedge clk);
        run('{rpin: 5'h5, fpin_en: 1'b0, fpin: 4'h0, fmt: 16'h0000, perr_en: 1'b0, tmo_en: 1'b0,
            tmo_ms: 16'h0, act_count: 4'h2});
        repeat (10) @(negedge clk);
        tx.send(8'h41, 1'b0, 1'b0, PER);
        tx.send(8'h31, 1'b0, 1'b0, PER);
        tx.send(8'h30, 1'b0, 1'b0, PER);
        wait_exit();
        cmp("bin", 16'h0002, got_num);
        cmp_flag("done list", 1'b1, got_exit.done);
        $display("test 4 done");
        results();
    end
endmodule
`default_nettype wire
